/* pkg/branch_skip_defs.vh */
// constants for the compare, skip, branch and load execution unit
`ifndef BRANCH_SKIP_DEFS_VH
`define BRANCH_SKIP_DEFS_VH

// register byte offsets
`define BSX_OFF_OP      8'h00
`define BSX_OFF_OPND    8'h04
`define BSX_OFF_KVAL    8'h08
`define BSX_OFF_PC      8'h0C
`define BSX_OFF_FLAGS   8'h10
`define BSX_OFF_PTR     8'h14
`define BSX_OFF_RESULT  8'h18
`define BSX_OFF_STATUS  8'h1C

// field positions
`define BSX_OP_MSB      4
`define BSX_OP_LSB      0
`define BSX_BIT_MSB     10
`define BSX_BIT_LSB     8
`define BSX_LONG_BIT    16
`define BSX_RD_MSB      7
`define BSX_RD_LSB      0
`define BSX_RR_MSB      15
`define BSX_RR_LSB      8
`define BSX_ST_BUSY     0
`define BSX_ST_TAKEN    1
`define BSX_ST_BADOP    2
`define BSX_ST_CYC_MSB  15
`define BSX_ST_CYC_LSB  8

// status flag positions
`define BSX_FLAG_C      0
`define BSX_FLAG_Z      1
`define BSX_FLAG_N      2
`define BSX_FLAG_V      3
`define BSX_FLAG_S      4
`define BSX_FLAG_H      5
`define BSX_FLAG_T      6
`define BSX_FLAG_I      7

// operation codes
`define OP_COMPARE_REGS          5'h00
`define OP_COMPARE_WITH_CARRY    5'h01
`define OP_COMPARE_IMMEDIATE     5'h02
`define OP_COMPARE_SKIP_EQUAL    5'h03
`define OP_SKIP_REG_BIT_CLEAR    5'h04
`define OP_SKIP_REG_BIT_SET      5'h05
`define OP_SKIP_IO_BIT_CLEAR     5'h06
`define OP_SKIP_IO_BIT_SET       5'h07
`define OP_BRANCH_STATUS_SET     5'h08
`define OP_BRANCH_STATUS_CLEAR   5'h09
`define OP_BRANCH_SAME_OR_HIGHER 5'h0A
`define OP_BRANCH_LOWER          5'h0B
`define OP_BRANCH_SIGNED_GE      5'h0C
`define OP_BRANCH_SIGNED_LESS    5'h0D
`define OP_BRANCH_HALF_SET       5'h0E
`define OP_BRANCH_HALF_CLEAR     5'h0F
`define OP_BRANCH_OVF_SET        5'h10
`define OP_BRANCH_OVF_CLEAR      5'h11
`define OP_BRANCH_IRQ_ENABLED    5'h12
`define OP_BRANCH_IRQ_DISABLED   5'h13
`define OP_BRANCH_USER_SET       5'h14
`define OP_BRANCH_USER_CLEAR     5'h15
`define OP_LOAD_DIRECT           5'h16
`define OP_LOAD_INDIRECT         5'h17
`define OP_LOAD_POST_INC         5'h18
`define OP_LOAD_PRE_DEC          5'h19

// program counter steps and skip wait counts
`define BSX_STEP_NEXT   16'h0001
`define BSX_STEP_SHORT  16'h0002
`define BSX_STEP_LONG   16'h0003
`define BSX_WAIT_SHORT  2'h1
`define BSX_WAIT_LONG   2'h2

`endif

/* rtl/compare_flags.v */
// subtract-and-flag logic for the compare operations
`timescale 1ns/100ps
module compare_flags (
    // operands
    input  wire [7:0] left,
    input  wire [7:0] right,
    input  wire       carryIn,
    input  wire       zeroIn,
    input  wire       useCarry,
    // flags
    output wire       flagC,
    output wire       flagZ,
    output wire       flagN,
    output wire       flagV,
    output wire       flagS,
    output wire       flagH
);
    wire [7:0] diff;
    wire       borrow;

    assign diff   = left - right - {7'h00, (useCarry & carryIn)};
    assign borrow = useCarry & carryIn;
    assign flagH  = (~left[3] & right[3]) | (right[3] & diff[3]) | (diff[3] & ~left[3]);
    assign flagC  = (~left[7] & right[7]) | (right[7] & diff[7]) | (diff[7] & ~left[7]);
    assign flagV  = (left[7] & ~right[7] & ~diff[7]) | (~left[7] & right[7] & diff[7]);
    assign flagN  = diff[7];
    assign flagS  = flagN ^ flagV;
    // with carry the zero flag only stays set across a chain of equal bytes
    assign flagZ  = (diff == 8'h00) & (~useCarry | zeroIn | ~borrow & zeroIn);
endmodule

/* rtl/branch_condition.v */
// branch condition evaluation from the status flags
`timescale 1ns/100ps
`include "branch_skip_defs.vh"
module branch_condition (
    // operation
    input  wire [4:0] opCode,
    input  wire [2:0] bitSel,
    input  wire [7:0] flags,
    // result
    output reg        take
);
    always @* begin
        case (opCode)
            `OP_BRANCH_STATUS_SET:     take = flags[bitSel];
            `OP_BRANCH_STATUS_CLEAR:   take = ~flags[bitSel];
            `OP_BRANCH_SAME_OR_HIGHER: take = ~flags[`BSX_FLAG_C];
            `OP_BRANCH_LOWER:          take = flags[`BSX_FLAG_C];
            `OP_BRANCH_SIGNED_GE:      take = ~(flags[`BSX_FLAG_N] ^ flags[`BSX_FLAG_V]);
            `OP_BRANCH_SIGNED_LESS:    take = flags[`BSX_FLAG_N] ^ flags[`BSX_FLAG_V];
            `OP_BRANCH_HALF_SET:       take = flags[`BSX_FLAG_H];
            `OP_BRANCH_HALF_CLEAR:     take = ~flags[`BSX_FLAG_H];
            `OP_BRANCH_OVF_SET:        take = flags[`BSX_FLAG_V];
            `OP_BRANCH_OVF_CLEAR:      take = ~flags[`BSX_FLAG_V];
            `OP_BRANCH_IRQ_ENABLED:    take = flags[`BSX_FLAG_I];
            `OP_BRANCH_IRQ_DISABLED:   take = ~flags[`BSX_FLAG_I];
            `OP_BRANCH_USER_SET:       take = flags[`BSX_FLAG_T];
            `OP_BRANCH_USER_CLEAR:     take = ~flags[`BSX_FLAG_T];
            default:                   take = 1'b0;
        endcase
    end
endmodule

/* rtl/branch_skip_exec.v */
// execution unit for compares, skips, flag branches and data loads behind an APB slave
`timescale 1ns/100ps
`include "branch_skip_defs.vh"
module branch_skip_exec #(
    parameter ADDR_W = 16,
    parameter OFFS_W = 7
) (
    // clock and reset
    input  wire              clk_sys,
    input  wire              rst_n,
    // apb slave
    input  wire [7:0]        paddr,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    // data and i/o space read port
    output reg  [ADDR_W-1:0] memAddr,
    output reg               memRead,
    output reg               memIo,
    input  wire [7:0]        memRdata,
    input  wire              memReady
);
    localparam S_IDLE = 5'b00001;
    localparam S_EXEC = 5'b00010;
    localparam S_DEC  = 5'b00100;
    localparam S_MEM  = 5'b01000;
    localparam S_WAIT = 5'b10000;

    // program counter after a skip, one- or two-word successor
    function [ADDR_W-1:0] skipTarget;
        input [ADDR_W-1:0] base;
        input              longNext;
        begin
            skipTarget = longNext ? base + `BSX_STEP_LONG : base + `BSX_STEP_SHORT;
        end
    endfunction

    // extra cycles spent on a skip
    function [1:0] skipWait;
        input longNext;
        begin
            skipWait = longNext ? `BSX_WAIT_LONG : `BSX_WAIT_SHORT;
        end
    endfunction

    function isBranch;
        input [4:0] op;
        begin
            isBranch = (op >= `OP_BRANCH_STATUS_SET) && (op <= `OP_BRANCH_USER_CLEAR);
        end
    endfunction

    function isLoad;
        input [4:0] op;
        begin
            isLoad = (op >= `OP_LOAD_DIRECT) && (op <= `OP_LOAD_PRE_DEC);
        end
    endfunction

    // software-visible state
    reg  [4:0]        opCode;
    reg  [2:0]        bitSel;
    reg               nextLong;
    reg  [7:0]        opndD;
    reg  [7:0]        opndR;
    reg  [ADDR_W-1:0] kVal;
    reg  [ADDR_W-1:0] pc;
    reg  [7:0]        flags;
    reg  [ADDR_W-1:0] ptr;
    reg  [7:0]        result;
    reg               taken;
    reg               badOp;
    reg  [7:0]        cycles;
    // sequencing
    reg  [4:0]        state;
    reg  [1:0]        waitCnt;
    // combinational
    reg  [31:0]       readMux;
    reg               addrOk;
    reg               regSkip;
    reg               ioSkip;
    wire              branchTake;
    wire              cmpC;
    wire              cmpZ;
    wire              cmpN;
    wire              cmpV;
    wire              cmpS;
    wire              cmpH;
    wire              busy;
    wire              wrEn;
    wire              accessEnd;
    wire [ADDR_W-1:0] kExt;
    wire [ADDR_W-1:0] pcNext;
    wire [7:0]        cmpRight;
    wire [7:0]        nextFlags;

    assign busy      = (state != S_IDLE);
    assign accessEnd = psel & penable & pready;
    assign wrEn      = accessEnd & pwrite;
    assign kExt      = {{(ADDR_W-OFFS_W){kVal[OFFS_W-1]}}, kVal[OFFS_W-1:0]};
    assign pcNext    = pc + `BSX_STEP_NEXT;
    assign cmpRight  = opndR;

    compare_flags u_compare (
        .left     (opndD),
        .right    (cmpRight),
        .carryIn  (flags[`BSX_FLAG_C]),
        .zeroIn   (flags[`BSX_FLAG_Z]),
        .useCarry (opCode == `OP_COMPARE_WITH_CARRY),
        .flagC    (cmpC),
        .flagZ    (cmpZ),
        .flagN    (cmpN),
        .flagV    (cmpV),
        .flagS    (cmpS),
        .flagH    (cmpH)
    );

    branch_condition u_branch (
        .opCode (opCode),
        .bitSel (bitSel),
        .flags  (flags),
        .take   (branchTake)
    );

    // T and I are kept, the six arithmetic flags are replaced
    assign nextFlags = {flags[`BSX_FLAG_I], flags[`BSX_FLAG_T], cmpH, cmpS, cmpV, cmpN, cmpZ, cmpC};

    always @* begin
        case (opCode)
            `OP_COMPARE_SKIP_EQUAL: regSkip = (opndD == opndR);
            `OP_SKIP_REG_BIT_CLEAR: regSkip = ~opndR[bitSel];
            `OP_SKIP_REG_BIT_SET:   regSkip = opndR[bitSel];
            default:                regSkip = 1'b0;
        endcase
        ioSkip = (opCode == `OP_SKIP_IO_BIT_SET) ? memRdata[bitSel] : ~memRdata[bitSel];
    end

    // register read decode
    always @* begin
        readMux = 32'h00000000;
        addrOk  = 1'b1;
        case (paddr)
            `BSX_OFF_OP: begin
                readMux[`BSX_OP_MSB:`BSX_OP_LSB]   = opCode;
                readMux[`BSX_BIT_MSB:`BSX_BIT_LSB] = bitSel;
                readMux[`BSX_LONG_BIT]             = nextLong;
            end
            `BSX_OFF_OPND: begin
                readMux[`BSX_RD_MSB:`BSX_RD_LSB] = opndD;
                readMux[`BSX_RR_MSB:`BSX_RR_LSB] = opndR;
            end
            `BSX_OFF_KVAL:   readMux[ADDR_W-1:0] = kVal;
            `BSX_OFF_PC:     readMux[ADDR_W-1:0] = pc;
            `BSX_OFF_FLAGS:  readMux[7:0]        = flags;
            `BSX_OFF_PTR:    readMux[ADDR_W-1:0] = ptr;
            `BSX_OFF_RESULT: readMux[7:0]        = result;
            `BSX_OFF_STATUS: begin
                readMux[`BSX_ST_BUSY]                  = busy;
                readMux[`BSX_ST_TAKEN]                 = taken;
                readMux[`BSX_ST_BADOP]                 = badOp;
                readMux[`BSX_ST_CYC_MSB:`BSX_ST_CYC_LSB] = cycles;
            end
            default:         addrOk = 1'b0;
        endcase
    end

    // apb answer one cycle into the access phase
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h00000000 : readMux;
            pslverr <= ~addrOk;
        end else begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
    end

    // register writes, execution sequencing and data port
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            opCode   <= 5'h00;
            bitSel   <= 3'h0;
            nextLong <= 1'b0;
            opndD    <= 8'h00;
            opndR    <= 8'h00;
            kVal     <= {ADDR_W{1'b0}};
            pc       <= {ADDR_W{1'b0}};
            flags    <= 8'h00;
            ptr      <= {ADDR_W{1'b0}};
            result   <= 8'h00;
            taken    <= 1'b0;
            badOp    <= 1'b0;
            cycles   <= 8'h00;
            state    <= S_IDLE;
            waitCnt  <= 2'h0;
            memAddr  <= {ADDR_W{1'b0}};
            memRead  <= 1'b0;
            memIo    <= 1'b0;
        end else begin
            if (busy) begin
                cycles <= cycles + 8'h01;
            end
            case (state)
                S_IDLE: begin
                    if (wrEn) begin
                        case (paddr)
                            `BSX_OFF_OP: begin
                                opCode   <= pwdata[`BSX_OP_MSB:`BSX_OP_LSB];
                                bitSel   <= pwdata[`BSX_BIT_MSB:`BSX_BIT_LSB];
                                nextLong <= pwdata[`BSX_LONG_BIT];
                                taken    <= 1'b0;
                                badOp    <= 1'b0;
                                cycles   <= 8'h00;
                                state    <= S_EXEC;
                            end
                            `BSX_OFF_OPND: begin
                                opndD <= pwdata[`BSX_RD_MSB:`BSX_RD_LSB];
                                opndR <= pwdata[`BSX_RR_MSB:`BSX_RR_LSB];
                            end
                            `BSX_OFF_KVAL:  kVal  <= pwdata[ADDR_W-1:0];
                            `BSX_OFF_PC:    pc    <= pwdata[ADDR_W-1:0];
                            `BSX_OFF_FLAGS: flags <= pwdata[7:0];
                            `BSX_OFF_PTR:   ptr   <= pwdata[ADDR_W-1:0];
                            default: begin
                            end
                        endcase
                    end
                end
                S_EXEC: begin
                    if (opCode <= `OP_COMPARE_IMMEDIATE) begin
                        flags <= nextFlags;
                        pc    <= pcNext;
                        state <= S_IDLE;
                    end else if (opCode <= `OP_SKIP_REG_BIT_SET) begin
                        if (regSkip) begin
                            pc      <= skipTarget(pc, nextLong);
                            taken   <= 1'b1;
                            waitCnt <= skipWait(nextLong);
                            state   <= S_WAIT;
                        end else begin
                            pc    <= pcNext;
                            state <= S_IDLE;
                        end
                    end else if (opCode <= `OP_SKIP_IO_BIT_SET) begin
                        memAddr <= kVal;
                        memIo   <= 1'b1;
                        memRead <= 1'b1;
                        state   <= S_MEM;
                    end else if (isBranch(opCode)) begin
                        if (branchTake) begin
                            pc      <= pc + kExt + `BSX_STEP_NEXT;
                            taken   <= 1'b1;
                            waitCnt <= `BSX_WAIT_SHORT;
                            state   <= S_WAIT;
                        end else begin
                            pc    <= pcNext;
                            state <= S_IDLE;
                        end
                    end else if (opCode == `OP_LOAD_PRE_DEC) begin
                        ptr   <= ptr - `BSX_STEP_NEXT;
                        state <= S_DEC;
                    end else if (isLoad(opCode)) begin
                        memAddr <= (opCode == `OP_LOAD_DIRECT) ? kVal : ptr;
                        memIo   <= 1'b0;
                        memRead <= 1'b1;
                        state   <= S_MEM;
                    end else begin
                        badOp <= 1'b1;
                        pc    <= pcNext;
                        state <= S_IDLE;
                    end
                end
                S_DEC: begin
                    memAddr <= ptr;
                    memIo   <= 1'b0;
                    memRead <= 1'b1;
                    state   <= S_MEM;
                end
                S_MEM: begin
                    if (memReady) begin
                        memRead <= 1'b0;
                        memIo   <= 1'b0;
                        if (memIo) begin
                            if (ioSkip) begin
                                pc      <= skipTarget(pc, nextLong);
                                taken   <= 1'b1;
                                waitCnt <= skipWait(nextLong);
                                state   <= S_WAIT;
                            end else begin
                                pc    <= pcNext;
                                state <= S_IDLE;
                            end
                        end else begin
                            result <= memRdata;
                            state  <= S_IDLE;
                            if (opCode == `OP_LOAD_DIRECT) begin
                                pc <= pc + `BSX_STEP_SHORT;
                            end else begin
                                pc <= pcNext;
                            end
                            if (opCode == `OP_LOAD_POST_INC) begin
                                ptr <= ptr + `BSX_STEP_NEXT;
                            end
                        end
                    end
                end
                S_WAIT: begin
                    if (waitCnt <= `BSX_WAIT_SHORT) begin
                        state <= S_IDLE;
                    end
                    waitCnt <= waitCnt - 2'h1;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule

/* dv/branch_skip_exec_sva.sv */
// concurrent checks on the apb and memory read ports of the execution unit
`timescale 1ns/100ps
module branch_skip_exec_sva #(
    parameter ADDR_W = 16,
    parameter OFFS_W = 7
) (
    // clock and reset
    input logic              clk_sys,
    input logic              rst_n,
    // apb slave
    input logic [7:0]        paddr,
    input logic              psel,
    input logic              penable,
    input logic              pwrite,
    input logic [31:0]       pwdata,
    input logic [31:0]       prdata,
    input logic              pready,
    input logic              pslverr,
    // memory read port
    input logic [ADDR_W-1:0] memAddr,
    input logic              memRead,
    input logic              memIo,
    input logic [7:0]        memRdata,
    input logic              memReady
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence sAccess;
        psel && penable && !pready;
    endsequence
    sequence sPulse;
        pready ##1 !pready;
    endsequence
    sequence sWaitMem;
        memRead && !memReady;
    endsequence
    a_one_wait: assert property (sAccess |=> sPulse)
        else $error("apb answer is not one pulse after one wait");
    a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
        else $error("pready without an access phase");
    a_idle_data: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside the answer");
    a_err_pulse: assert property (pslverr |-> pready)
        else $error("error flag without pready");
    a_unmapped_err: assert property (sAccess ##0 (paddr > 8'h1C || paddr[1:0] != 2'h0) |=> pslverr)
        else $error("unmapped access not flagged");
    a_mapped_ok: assert property (sAccess ##0 (paddr <= 8'h1C && paddr[1:0] == 2'h0) |=> !pslverr)
        else $error("mapped access flagged");
    a_mem_hold: assert property (sWaitMem |=> memRead && $stable(memAddr) && $stable(memIo))
        else $error("memory request changed before it was answered");
    a_mem_release: assert property (memRead && memReady |=> !memRead)
        else $error("memory request kept after its answer");
endmodule

bind branch_skip_exec branch_skip_exec_sva #(.ADDR_W(ADDR_W), .OFFS_W(OFFS_W)) branch_skip_exec_sva_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .memAddr(memAddr), .memRead(memRead), .memIo(memIo), .memRdata(memRdata), .memReady(memReady));

/* dv/test_branch_skip_exec.sv */
// self-checking bench for the compare, skip, branch and load unit
`timescale 1ns/100ps
`include "branch_skip_defs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module test_branch_skip_exec;
    logic        clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, memReady = 0;
    logic [7:0]  paddr = 0, memRdata = 0, flv, r8, res, iov = 8'h2E;
    logic [31:0] pwdata = 0, prdata, rd, st;
    logic [15:0] memAddr, pcv, lastAddr;
    logic        pready, pslverr, memRead, memIo, err, lastIo, sk, tk;
    logic [4:0]  o;
    int          failures = 0, compares = 0, lag = 0, waits = 0, cyc = 0;
    logic [31:0] cv[5] = '{32'h00101000, 32'h013F4003, 32'h01010003, 32'h028001C0, 32'h00000100};
    logic [7:0]  pat[4] = '{8'h00, 8'hFF, 8'h5A, 8'hA5};

    branch_skip_exec branch_skip_exec_i (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .memAddr(memAddr), .memRead(memRead), .memIo(memIo), .memRdata(memRdata),
        .memReady(memReady));

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    // memory answers after lag idle cycles; unread data keeps toggling
    always @(posedge clk_sys) begin
        if (memRead && !memReady && waits >= lag) begin
            memReady <= 1'b1;
            memRdata <= memAddr[7:0] ^ 8'h3C;
            lastAddr <= memAddr;
            lastIo <= memIo;
            waits <= 0;
        end else begin
            memReady <= 1'b0;
            memRdata <= ~memRdata;
            waits <= (memRead && !memReady) ? waits + 1 : 0;
        end
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            wrap_up;
        end
    end

    task wrap_up;
        if (failures == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    function automatic logic [31:0] opw(input logic [4:0] op, input logic [2:0] b, input logic l);
        return {15'h0, l, 5'h0, b, 3'h0, op};
    endfunction

    function automatic logic [15:0] nextPc(input logic s, input logic l);
        return 16'h0100 + (s ? 16'h0002 + l : 16'h0001);
    endfunction

    task automatic exec(input logic [31:0] op, input logic [31:0] od, input logic [31:0] k, input logic [7:0] fl);
        apb(1, `BSX_OFF_OPND, od);
        apb(1, `BSX_OFF_KVAL, k);
        apb(1, `BSX_OFF_FLAGS, {24'h0, fl});
        apb(1, `BSX_OFF_PC, 32'h00000100);
        apb(1, `BSX_OFF_PTR, 32'h00000040);
        apb(1, `BSX_OFF_OP, op);
        do begin
            apb(0, `BSX_OFF_STATUS, 0);
        end while (rd[0] !== 1'b0);
        st = rd;
        apb(0, `BSX_OFF_PC, 0);
        pcv = rd[15:0];
        apb(0, `BSX_OFF_FLAGS, 0);
        flv = rd[7:0];
    endtask

    task automatic checkLoad(input logic [4:0] op, input logic [15:0] a, input logic [15:0] p, input logic [15:0] c);
        exec(opw(op, 3'h0, 1'b0), 0, 32'h00001234, 8'h5A);
        apb(0, `BSX_OFF_RESULT, 0);
        res = rd[7:0];
        apb(0, `BSX_OFF_PTR, 0);
        `CHK({pcv, flv, res, lastAddr, lastIo, rd[15:0]}, {c, 8'h5A, a[7:0] ^ 8'h3C, a, 1'b0, p})
        // the memory model answers one cycle after the request, plus lag
        `CHK(st[15:8], 8'h03 + lag[7:0] + {7'h0, op == `OP_LOAD_PRE_DEC})
    endtask

    function automatic logic [7:0] expCmp(input logic [7:0] d, input logic [7:0] r, input logic [7:0] f,
                                          input logic useC);
        logic [8:0] w;
        logic [4:0] h;
        logic       c, v;
        c = useC & f[`BSX_FLAG_C];
        w = {1'b0, d} - {1'b0, r} - {8'h0, c};
        h = {1'b0, d[3:0]} - {1'b0, r[3:0]} - {4'h0, c};
        v = (d[7] != r[7]) && (w[7] != d[7]);
        return {f[7:6], h[4], w[7] ^ v, v, w[7], (w[7:0] == 8'h00) & (~useC | f[`BSX_FLAG_Z]), w[8]};
    endfunction

    function automatic logic expTake(input logic [4:0] op, input logic [2:0] b, input logic [7:0] f);
        logic v;
        case (op[4:1])
            4'h4: v = f[b];
            4'h5: v = ~f[`BSX_FLAG_C];
            4'h6: v = ~(f[`BSX_FLAG_N] ^ f[`BSX_FLAG_V]);
            4'h7: v = f[`BSX_FLAG_H];
            4'h8: v = f[`BSX_FLAG_V];
            4'h9: v = f[`BSX_FLAG_I];
            default: v = f[`BSX_FLAG_T];
        endcase
        return v ^ op[0];
    endfunction

    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        apb(0, `BSX_OFF_PC, 0);
        `CHK(rd, 32'h0)
        apb(0, 8'h20, 0);
        `CHK({err, rd}, 33'h100000000)
        apb(1, `BSX_OFF_RESULT, 32'h000000FF);
        apb(0, `BSX_OFF_RESULT, 0);
        `CHK({err, rd}, 33'h0)
        foreach (cv[i]) begin
            exec({27'h0, cv[i][28:24]}, {16'h0, cv[i][15:8], cv[i][23:16]}, 0, cv[i][7:0]);
            `CHK({flv, pcv, st[15:8]}, {expCmp(cv[i][23:16], cv[i][15:8], cv[i][7:0], cv[i][24]), 24'h010101})
        end
        for (int i = 0; i < 24; i++) begin
            o = 5'h03 + i % 3;
            r8 = i[4] ? 8'hC3 : 8'h5A;
            sk = (o == 5'h03) ? !i[4] : (r8[i[2:0]] ^ (o == 5'h04));
            exec(opw(o, i[2:0], i[3]), {16'h0, r8, 8'h5A}, 0, 8'h96);
            `CHK({pcv, flv, st[15:8], st[1]}, {nextPc(sk, i[3]), 8'h96, sk ? 8'h02 + i[3] : 8'h01, sk})
        end
        for (int i = 0; i < 16; i++) begin
            lag = i[1] ? 3 : 0;
            sk = iov[i[3:1]] ^ !i[0];
            exec(opw(5'h06 + i[0], i[3:1], i[2]), 0, 32'h00000012, 8'h00);
            `CHK({pcv, st[1], lastAddr, lastIo}, {nextPc(sk, i[2]), sk, 16'h0012, 1'b1})
            `CHK(st[15:8], 8'h03 + lag[7:0] + (sk ? 8'h01 + {7'h0, i[2]} : 8'h00))
        end
        for (int k = 8; k < 22; k++) begin
            foreach (pat[p]) begin
                tk = expTake(k[4:0], k[2:0] ^ p[2:0], pat[p]);
                exec(opw(k[4:0], k[2:0] ^ p[2:0], 1'b0), 0, 32'h0000007E, pat[p]);
                `CHK({pcv, flv, st[15:8], st[1]}, {tk ? 16'h00FF : 16'h0101, pat[p], tk ? 8'h02 : 8'h01, tk})
            end
        end
        exec(opw(`OP_BRANCH_USER_SET, 3'h0, 1'b0), 0, 32'h0000003F, 8'h40);
        `CHK(pcv, 16'h0140)
        exec(opw(5'h1F, 3'h0, 1'b0), 0, 0, 8'hA5);
        `CHK({pcv, flv, st[15:8], st[2:1]}, {16'h0101, 8'hA5, 8'h01, 2'h2})
        checkLoad(`OP_LOAD_DIRECT, 16'h1234, 16'h0040, 16'h0102);
        lag = 0;
        checkLoad(`OP_LOAD_INDIRECT, 16'h0040, 16'h0040, 16'h0101);
        checkLoad(`OP_LOAD_POST_INC, 16'h0040, 16'h0041, 16'h0101);
        checkLoad(`OP_LOAD_PRE_DEC, 16'h003F, 16'h003F, 16'h0101);
        wrap_up;
    end
endmodule
